/* File: verilog/ira_pkg.sv */
/*
  Shared constants, carriers and the address attribute decoder for the
  two-wire register access block. Assumes a byte-wide register map.
*/
package ira_pkg;

  // ************************************************************
  // map layout
  // ************************************************************
  localparam int MEM_AW = 12;
  localparam logic [15:0] MAP_LAST = 16'h0e3c;
  localparam logic [15:0] COMMIT_ADDR = 16'h0005;
  localparam logic [7:0] COMMIT_VAL = 8'h01;
  localparam logic [15:0] SEQ_FIRST = 16'h0e10;
  localparam logic [15:0] EXCL_LAST = 16'h000f;
  localparam logic [15:0] WIN_BASE = 16'h0100;
  localparam int WIN_BYTES = 16;
  localparam logic [15:0] LIVE_FIRST = 16'h0100;
  localparam logic [15:0] LIVE_LAST = 16'h0103;
  localparam logic [15:0] AUTOCLR_ADDR = 16'h0104;
  localparam int AUTOCLR_OFF = 4;
  localparam logic [15:0] RO_BASE = 16'h0d00;
  localparam int RO_BYTES = 16;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] SLV_ADDR_DEF = 7'h48; // arbitrary default

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic impl;
    logic ro;
    logic win;
    logic live;
    logic excl;
    logic seq;
  } ira_attr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ira_ee_req_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RX = 6'h04,
    ST_ACK = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } ira_st_t;

  // attribute of one byte address
  function automatic ira_attr_t regAttr(input logic [15:0] a);
    ira_attr_t t;
    t.impl = (a <= MAP_LAST);
    t.ro = (a >= RO_BASE) && (32'(a) < 32'(RO_BASE) + RO_BYTES);
    t.win = (a >= WIN_BASE) && (32'(a) < 32'(WIN_BASE) + WIN_BYTES);
    t.live = (a >= LIVE_FIRST) && (a <= LIVE_LAST);
    t.seq = (a >= SEQ_FIRST) && (a <= MAP_LAST);
    t.excl = t.ro || (a <= EXCL_LAST);
    return t;
  endfunction : regAttr

endpackage : ira_pkg

/* File: verilog/ira_byte_mem.sv */
/*
  Single-port byte memory for the buffered register copies.
  Assumes one owner at a time drives the port; read data is registered.
*/
`timescale 1ns/100ps
module ira_byte_mem #(
  parameter int AW = 12,
  parameter int DEPTH = 3645
) (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic we, // write strobe
  input wire logic [AW-1:0] addr, // byte address
  input wire logic [7:0] wdata, // write byte
  output logic [7:0] rdata // byte at last cycle's address
);

  logic [7:0] mem [DEPTH];

  // ************************************************************
  // storage
  // ************************************************************
  // array left without reset so it maps onto a ram macro
  always_ff @(posedge core_clk) begin
    if (we && (32'(addr) < DEPTH)) begin
      mem[addr] <= wdata;
    end
  end

  // registered read, out-of-range reads give zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= (32'(addr) < DEPTH) ? mem[addr] : 8'h00;
    end
  end

endmodule : ira_byte_mem

/* File: verilog/ira_i2c_regs.sv */
/*
  Two-wire slave front end with the register map, buffered/active
  window, live and autoclear bytes, and serial/EEPROM arbitration.
  Assumes open-drain pads resolve sdaOut/sdaOe, and that the EEPROM
  controller and status logic run on core_clk.
*/
`timescale 1ns/100ps
module ira_i2c_regs
  import ira_pkg::*;
#(
  parameter logic [6:0] SLV_ADDR = ira_pkg::SLV_ADDR_DEF // arbitrary default
) (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // power-on reset, active low
  input wire logic sclIn, // clock pin level
  input wire logic sdaIn, // data pin level
  output logic sdaOut, // data pin drive value
  output logic sdaOe, // data pin pulled low when high
  input wire logic eeBusy, // EEPROM controller loading or storing
  input wire ira_pkg::ira_ee_req_t eeReq, // EEPROM controller access
  output logic eeAck, // EEPROM access done pulse
  output logic [7:0] eeRdata, // EEPROM read byte
  input wire logic [7:0] actionDone, // autoclear action finished pulses
  input wire logic [ira_pkg::RO_BYTES*8-1:0] statusIn, // read-only bytes
  output logic [ira_pkg::WIN_BYTES*8-1:0] activeRegs // active window
);
  import ira_pkg::*;
  localparam int WW = WIN_BYTES * 8;
  typedef struct packed {
    ira_st_t st;
    logic sclQ1;
    logic sclQ2;
    logic sclP;
    logic sdaQ1;
    logic sdaQ2;
    logic sdaP;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic rw;
    logic [15:0] ptr;
    logic sdaOe;
    logic [WW-1:0] bufWin;
    logic [WW-1:0] actWin;
    logic eeRd;
    logic eeOk;
    logic [15:0] eeAddr;
    logic eeAck;
    logic [7:0] eeRdata;
  } ira_state_t;
  ira_state_t s_r, s_nxt;
  logic memWe;
  logic [MEM_AW-1:0] memAddr;
  logic [7:0] memWdata;
  logic [7:0] memRdata;
  // byte of the window vector at a map address
  function automatic logic [7:0] winByte(input logic [WW-1:0] v, input logic [15:0] a);
    logic [15:0] d;
    d = a - WIN_BASE;
    return v[{d[3:0], 3'b000} +: 8];
  endfunction : winByte
  // byte of the status vector at a map address
  function automatic logic [7:0] roByte(input logic [RO_BYTES*8-1:0] v, input logic [15:0] a);
    logic [15:0] d;
    d = a - RO_BASE;
    return v[{d[3:0], 3'b000} +: 8];
  endfunction : roByte
  // ************************************************************
  // buffered byte storage
  // ************************************************************
  ira_byte_mem #(
    .AW(MEM_AW),
    .DEPTH(32'(MAP_LAST) + 1)
  ) u_mem (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .we(memWe),
    .addr(memAddr),
    .wdata(memWdata),
    .rdata(memRdata)
  );
  // ************************************************************
  // next-state logic
  // ************************************************************
  logic sclRise, sclFall, startEv, stopEv, serOwn;
  ira_attr_t pa, ea, qa;
  logic [7:0] rdByte;
  always_comb begin
    s_nxt = s_r;
    // two-stage pin synchronisers, third stage only for edge history
    s_nxt.sclQ1 = sclIn;
    s_nxt.sclQ2 = s_r.sclQ1;
    s_nxt.sclP = s_r.sclQ2;
    s_nxt.sdaQ1 = sdaIn;
    s_nxt.sdaQ2 = s_r.sdaQ1;
    s_nxt.sdaP = s_r.sdaQ2;
    sclRise = s_r.sclQ2 & ~s_r.sclP;
    sclFall = ~s_r.sclQ2 & s_r.sclP;
    startEv = s_r.sclQ2 & s_r.sclP & s_r.sdaP & ~s_r.sdaQ2;
    stopEv = s_r.sclQ2 & s_r.sclP & ~s_r.sdaP & s_r.sdaQ2;
    serOwn = ~eeBusy;
    pa = regAttr(s_r.ptr);
    ea = regAttr(eeReq.addr);
    qa = regAttr(s_r.eeAddr);
    memWe = 1'b0;
    memAddr = s_r.ptr[MEM_AW-1:0];
    memWdata = s_r.shift;
    s_nxt.eeAck = 1'b0;
    s_nxt.eeRd = 1'b0;
    // read mux: strictest category decides the byte returned
    if (!pa.impl || s_r.ptr == COMMIT_ADDR) begin
      rdByte = 8'h00;
    end else if (pa.ro) begin
      rdByte = roByte(statusIn, s_r.ptr);
    end else if (!serOwn) begin
      rdByte = 8'h00;
    end else if (pa.win) begin
      rdByte = winByte(s_r.bufWin, s_r.ptr);
    end else begin
      rdByte = memRdata;
    end
    // finished actions clear their bits in both copies
    s_nxt.actWin[AUTOCLR_OFF*8 +: 8] = s_r.actWin[AUTOCLR_OFF*8 +: 8] & ~actionDone;
    s_nxt.bufWin[AUTOCLR_OFF*8 +: 8] = s_r.bufWin[AUTOCLR_OFF*8 +: 8] & ~actionDone;
    // serial protocol engine
    if (startEv) begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitCnt = 4'h0;
      s_nxt.byteIdx = 2'd0;
      s_nxt.sdaOe = 1'b0;
    end else if (stopEv) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sdaOe = 1'b0;
    end else begin
      unique case (s_r.st)
        ST_IDLE: s_nxt.sdaOe = 1'b0;
        ST_ADDR, ST_RX: begin
          if (sclRise && s_r.bitCnt < BITS_PER_BYTE) begin
            s_nxt.shift = {s_r.shift[6:0], s_r.sdaQ2};
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
          end else if (sclFall && s_r.bitCnt == BITS_PER_BYTE) begin
            s_nxt.bitCnt = 4'h0;
            if (s_r.st == ST_ADDR) begin
              if (s_r.shift[7:1] == SLV_ADDR) begin
                s_nxt.rw = s_r.shift[0];
                s_nxt.sdaOe = 1'b1;
                s_nxt.st = ST_ACK;
              end else begin
                s_nxt.st = ST_IDLE;
              end
            end else begin
              s_nxt.sdaOe = 1'b1;
              s_nxt.st = ST_ACK;
              unique case (s_r.byteIdx)
                2'd0: s_nxt.ptr[15:8] = s_r.shift;
                2'd1: s_nxt.ptr[7:0] = s_r.shift;
                default: begin
                  s_nxt.ptr = s_r.ptr + 16'h0001;
                  if (pa.impl && !pa.ro && serOwn) begin
                    if (s_r.ptr == COMMIT_ADDR) begin
                      if (s_r.shift == COMMIT_VAL) begin
                        s_nxt.actWin = s_r.bufWin;
                      end
                    end else begin
                      memWe = 1'b1;
                      if (pa.win) begin
                        s_nxt.bufWin[{s_r.ptr[3:0], 3'b000} +: 8] = s_r.shift;
                        if (pa.live) begin
                          s_nxt.actWin[{s_r.ptr[3:0], 3'b000} +: 8] = s_r.shift;
                        end
                      end
                    end
                  end
                end
              endcase
              if (s_r.byteIdx != 2'd2) begin
                s_nxt.byteIdx = s_r.byteIdx + 2'd1;
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            s_nxt.bitCnt = 4'h0;
            if (s_r.rw) begin
              s_nxt.st = ST_TX;
              s_nxt.shift = rdByte;
              s_nxt.sdaOe = ~rdByte[7];
            end else begin
              s_nxt.st = ST_RX;
              s_nxt.sdaOe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (s_r.bitCnt == 4'h7) begin
              s_nxt.sdaOe = 1'b0;
              s_nxt.st = ST_MACK;
              s_nxt.ptr = s_r.ptr + 16'h0001;
            end else begin
              s_nxt.shift = {s_r.shift[6:0], 1'b0};
              s_nxt.bitCnt = s_r.bitCnt + 4'h1;
              s_nxt.sdaOe = ~s_r.shift[6];
            end
          end
        end
        ST_MACK: begin
          if (sclRise && s_r.sdaQ2) begin
            s_nxt.st = ST_IDLE;
          end else if (sclFall) begin
            s_nxt.st = ST_TX;
            s_nxt.shift = rdByte;
            s_nxt.sdaOe = ~rdByte[7];
            s_nxt.bitCnt = 4'h0;
          end
        end
        default: begin
          s_nxt.st = ST_IDLE;
          s_nxt.sdaOe = 1'b0;
        end
      endcase
    end
    // EEPROM controller owns the port only while busy
    if (eeBusy) begin
      memAddr = eeReq.addr[MEM_AW-1:0];
      memWdata = eeReq.wdata;
      if (eeReq.req) begin
        s_nxt.eeOk = ea.impl && !ea.excl;
        s_nxt.eeAddr = eeReq.addr;
        if (eeReq.we) begin
          s_nxt.eeAck = 1'b1;
          if (ea.impl && !ea.excl) begin
            memWe = 1'b1;
            if (ea.win) begin
              s_nxt.bufWin[{eeReq.addr[3:0], 3'b000} +: 8] = eeReq.wdata;
            end
          end
        end else begin
          s_nxt.eeRd = 1'b1;
        end
      end
    end
    // read byte answered two cycles after the request
    if (s_r.eeRd) begin
      s_nxt.eeAck = 1'b1;
      if (!s_r.eeOk) begin
        s_nxt.eeRdata = 8'h00;
      end else if (qa.win) begin
        s_nxt.eeRdata = winByte(s_r.bufWin, s_r.eeAddr);
      end else begin
        s_nxt.eeRdata = memRdata;
      end
    end
  end
  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: ST_IDLE, sclQ1: 1'b1, sclQ2: 1'b1, sclP: 1'b1, sdaQ1: 1'b1,
               sdaQ2: 1'b1, sdaP: 1'b1, shift: BYTE_RST, bitCnt: 4'h0, byteIdx: 2'd0,
               rw: 1'b0, ptr: 16'h0000, sdaOe: 1'b0, bufWin: '0, actWin: '0,
               eeRd: 1'b0, eeOk: 1'b0, eeAddr: 16'h0000, eeAck: 1'b0,
               eeRdata: BYTE_RST};
    end else begin
      s_r <= s_nxt;
    end
  end
  // outputs straight from the state register, except sdaOut which is tied low
  assign sdaOut = 1'b0;
  assign sdaOe = s_r.sdaOe;
  assign eeAck = s_r.eeAck;
  assign eeRdata = s_r.eeRdata;
  assign activeRegs = s_r.actWin;
endmodule : ira_i2c_regs

/* File: test/ira_i2c_master.sv */
/*
  Two-wire bus master model that drives the register block's pins.
  Assumes a pull-up on the data wire; the bench resolves it from sdaDrv and the block's enable.
*/
`timescale 1ns/100ps
module ira_i2c_master (
  input wire logic core_clk, // pacing clock
  input wire logic sdaLine, // resolved data wire
  output logic scl, // clock pin, stands high between frames
  output logic sdaDrv, // data drive, 1 releases the wire
  output logic rdValid, // one-cycle strobe per byte read
  output logic [7:0] rdByte // byte just read
);
  // ************************
  // bit and byte tasks
  // ************************
  // pins idle released at time zero
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    rdValid = 1'b0;
    rdByte = 8'h00;
  end
  // 4 cycles per step keeps each clock phase at least 4 cycles long
  task automatic hp();
    repeat (4) @(negedge core_clk);
  endtask : hp
  // data only moves while the clock is low
  task automatic bitOut(input logic b);
    hp();
    sdaDrv = b;
    hp();
    scl = 1'b1;
    hp();
    scl = 1'b0;
  endtask : bitOut
  task automatic bitIn(output logic b);
    hp();
    sdaDrv = 1'b1;
    hp();
    b = sdaLine;
    scl = 1'b1;
    hp();
    scl = 1'b0;
  endtask : bitIn
  // also serves as repeated start when the clock is low
  task automatic start();
    hp();
    sdaDrv = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sdaDrv = 1'b0;
    hp();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    hp();
    sdaDrv = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sdaDrv = 1'b1;
    hp();
  endtask : stop
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(b);
    ack = !b;
  endtask : wrByte
  // nack on the last byte ends the read
  task automatic rdB(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(last);
    rdByte = d;
    rdValid = 1'b1;
    @(negedge core_clk);
    rdValid = 1'b0;
  endtask : rdB
endmodule : ira_i2c_master

/* File: test/ira_i2c_regs_props.sv */
/*
  Checker on the register block's pins.
  Assumes one clock domain and the active-low async reset.
*/
`timescale 1ns/100ps
module ira_i2c_regs_props
  import ira_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset
  input wire logic sclIn, // clock pin
  input wire logic sdaOut, // data drive value
  input wire logic sdaOe, // data drive enable
  input wire logic eeBusy, // eeprom active
  input wire ira_pkg::ira_ee_req_t eeReq, // eeprom access
  input wire logic eeAck, // eeprom done
  input wire logic [7:0] eeRdata, // eeprom read byte
  input wire logic [ira_pkg::WIN_BYTES*8-1:0] activeRegs // active window
);
  // ************************
  // pin and eeprom port rules
  // ************************
  logic wrGo;
  logic rdGo;
  // accepted eeprom requests by direction
  assign wrGo = eeBusy && eeReq.req && eeReq.we;
  assign rdGo = eeBusy && eeReq.req && !eeReq.we;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence rdAns;
    ##2 eeAck;
  endsequence
  sequence rdZero;
    ##2 eeRdata == 8'h00;
  endsequence
  drain_value_a: assert property (sdaOut == 1'b0)
    else $error("data drive value not low");
  oe_clock_low_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data enable moved while clock high");
  ee_wr_ack_a: assert property (wrGo |=> eeAck)
    else $error("eeprom write not acknowledged");
  ee_rd_ack_a: assert property (rdGo |-> rdAns)
    else $error("eeprom read not acknowledged");
  ack_cause_a: assert property (eeAck |-> $past(wrGo) || $past(rdGo, 2))
    else $error("eeprom ack without request");
  excl_zero_a: assert property (rdGo && eeReq.addr <= EXCL_LAST |-> rdZero)
    else $error("excluded byte leaked to eeprom");
  ro_zero_a: assert property (rdGo && eeReq.addr[15:4] == RO_BASE[15:4] |-> rdZero)
    else $error("read-only byte leaked to eeprom");
  absent_zero_a: assert property (rdGo && eeReq.addr > MAP_LAST |-> rdZero)
    else $error("absent byte read nonzero");
  // serial writes must not reach live bytes while eeprom owns the map
  live_hold_a: assert property ($past(eeBusy) && $past(eeBusy, 2) && !$past(wrGo)
    && !$past(wrGo, 2) |-> $stable(activeRegs[31:0]))
    else $error("live bytes moved during eeprom activity");
endmodule : ira_i2c_regs_props
bind ira_i2c_regs ira_i2c_regs_props u_props (.core_clk, .arst_n, .sclIn, .sdaOut, .sdaOe,
  .eeBusy, .eeReq, .eeAck, .eeRdata, .activeRegs);

/* File: test/ira_i2c_regs_tb.sv */
/*
  Self-checking bench for the register block with a bus master model.
  Assumes the checker is bound in and the design files compile first.
*/
`timescale 1ns/100ps
module ira_i2c_regs_tb;
  import ira_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic eeBusy = 1'b0;
  logic sclIn, sdaDrv, sdaLine, sdaOut, sdaOe, eeAck, rdValid;
  logic [7:0] eeRdata, actionDone, rdByte;
  logic [127:0] statusIn, activeRegs;
  ira_ee_req_t eeReq;
  logic [7:0] expQ[$];
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  // ************************
  // harness
  // ************************
  always #4 core_clk = ~core_clk;
  // wired-and with pull-up
  assign sdaLine = sdaDrv & (!sdaOe | sdaOut);
  ira_i2c_regs dut (.core_clk, .arst_n, .sclIn, .sdaIn(sdaLine), .sdaOut, .sdaOe, .eeBusy,
    .eeReq, .eeAck, .eeRdata, .actionDone, .statusIn, .activeRegs);
  ira_i2c_master m (.core_clk, .sdaLine, .scl(sclIn), .sdaDrv, .rdValid, .rdByte);
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // serial bytes read are matched against the oldest note
  always @(posedge core_clk) if (rdValid) check(rdByte, expQ.pop_front());
  // hang guard, a run needs about 8400 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic sendB(input logic [7:0] b, input logic ackExp);
    logic a;
    m.wrByte(b, a);
    check(a, ackExp);
  endtask : sendB
  // pointer high byte first; no stop so a read may follow
  task automatic setPtr(input logic [15:0] a);
    m.start();
    sendB({SLV_ADDR_DEF, 1'b0}, 1'b1);
    sendB(a[15:8], 1'b1);
    sendB(a[7:0], 1'b1);
  endtask : setPtr
  task automatic wr1(input logic [15:0] a, input logic [7:0] b);
    setPtr(a);
    sendB(b, 1'b1);
    m.stop();
  endtask : wr1
  task automatic rdN(input int n);
    m.start();
    sendB({SLV_ADDR_DEF, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) m.rdB(i == n - 1);
    m.stop();
  endtask : rdN
  task automatic ee(input logic we, input logic [15:0] a, input logic [7:0] b);
    eeReq = '{1'b1, we, a, b};
    @(negedge core_clk);
    eeReq.req = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : ee
  // ************************
  // scenarios
  // ************************
  initial begin
    logic [31:0] d;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    eeReq = '0;
    actionDone = 8'h00;
    statusIn = '0;
    void'($urandom(32'h9570));
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    statusIn = {$urandom, $urandom, $urandom, $urandom};
    d = $urandom;
    x = 8'($urandom);
    y = 8'($urandom);
    z = 8'($urandom);
    m.start();
    sendB({~SLV_ADDR_DEF, 1'b0}, 1'b0);
    m.stop();
    // live bytes act before any commit
    setPtr(LIVE_FIRST);
    for (int i = 0; i < 4; i++) sendB(d[8*i +: 8], 1'b1);
    m.stop();
    check(activeRegs[31:0], d);
    setPtr(16'h0105);
    sendB(x, 1'b1);
    sendB(y, 1'b1);
    m.stop();
    wr1(COMMIT_ADDR, 8'h02);
    check(activeRegs[55:40], 16'h0000);
    wr1(COMMIT_ADDR, COMMIT_VAL);
    check(activeRegs[55:40], {y, x});
    for (int i = 0; i < 4; i++) expQ.push_back(d[8*i +: 8]);
    setPtr(LIVE_FIRST);
    rdN(4);
    setPtr(16'h0105);
    m.stop();
    expQ.push_back(x);
    expQ.push_back(y);
    rdN(2);
    expQ.push_back(8'h00);
    setPtr(16'h0e3d);
    rdN(1);
    expQ.push_back(8'h00);
    setPtr(COMMIT_ADDR);
    rdN(1);
    wr1(AUTOCLR_ADDR, 8'hff);
    check(activeRegs[39:32], 8'h00);
    wr1(COMMIT_ADDR, COMMIT_VAL);
    check(activeRegs[39:32], 8'hff);
    actionDone = 8'h0f;
    @(negedge core_clk);
    actionDone = 8'h00;
    @(negedge core_clk);
    check(activeRegs[39:32], 8'hf0);
    // eeprom owns the map from here
    eeBusy = 1'b1;
    ee(1'b1, SEQ_FIRST, z);
    ee(1'b0, SEQ_FIRST, 8'h00);
    check(eeRdata, z);
    ee(1'b1, 16'h0003, z);
    ee(1'b0, 16'h0003, 8'h00);
    check(eeRdata, 8'h00);
    ee(1'b0, RO_BASE, 8'h00);
    check(eeRdata, 8'h00);
    ee(1'b0, 16'h0e3d, 8'h00);
    check(eeRdata, 8'h00);
    wr1(LIVE_FIRST, ~d[7:0]);
    expQ.push_back(8'h00);
    setPtr(LIVE_FIRST);
    rdN(1);
    expQ.push_back(statusIn[7:0]);
    setPtr(RO_BASE);
    rdN(1);
    eeBusy = 1'b0;
    check(activeRegs[7:0], d[7:0]);
    expQ.push_back(z);
    setPtr(SEQ_FIRST);
    rdN(1);
    summarize();
  end
endmodule : ira_i2c_regs_tb
